// file: design/uimb_uart.sv
// How it works
// - transmit interrupt stays high while the transmit holding register is empty
// - writing the transmit data register clears the transmit interrupt
// - a written byte moves to the shifter and is sent automatically
// - receive interrupt on byte ready, break, overrun or framing error
// - byte-ready interrupt has its own gate; errors always interrupt
// - every received byte raises the dma request, with or without errors
// - errors and breaks still interrupt while dma moves receive data
// - in address mode the address bit follows data, before stop bits
// - address mode replaces parity in the ninth bit position
// - received address bit is captured and readable before the data
// - ready flag is one while an unread byte is held, else zero
// - status register separates error, break and received byte causes
// - divider runs on the system clock with a sixteen bit divisor
// - each bit lasts sixteen times the divisor in system clocks
// - timer interrupt enable raises receive interrupt on each divider reload
// - timer use needs both enables off and the interrupt enable set
// - transmit and receive enables act independently
// - parity is optional, even or odd, on both directions
// - clear-to-send gate decides whether the clear-to-send input matters
// - low start bit, eight data bits lsb first, one or two stop bits
// - parity select zero gives even parity, one gives odd
// - with the gate set, a frame starts only while clear-to-send is low
// - reading receive data clears ready, parity, framing and break flags
`timescale 1ns/1ps
module uimb_uart
    import uimb_pkg::*;
(
    input wire logic ref_clk, // system clock
    input wire logic reset_n, // async reset
    input wire logic wb_cyc_i, // bus cycle
    input wire logic wb_stb_i, // strobe
    input wire logic wb_we_i, // write enable
    input wire logic [7:0] wb_adr_i, // byte address
    input wire logic [31:0] wb_dat_i, // write data
    input wire logic [3:0] wb_sel_i, // byte lanes
    output logic [31:0] wb_dat_o, // read data
    output logic wb_ack_o, // acknowledge
    input wire logic rxd, // serial in
    output logic txd, // serial out
    input wire logic cts_n, // clear to send, low active
    output logic tx_irq, // transmit interrupt
    output logic rx_irq, // receive interrupt
    output logic dma_req // receive byte ready for dma
);
    import uimb_pkg::*;

    logic rxd_meta, rxd_sync, cts_meta, cts_sync;
    logic [7:0] ctl0, ctl1, baud_hi, baud_lo;
    logic [15:0] baud_cnt;
    logic tick, reload;
    logic [7:0] tx_hold, tx_shift, rx_data, rx_shift;
    logic tx_empty, tx_busy;
    uimb_state_e tx_state, rx_state;
    logic [3:0] tx_tick, rx_tick;
    logic [2:0] tx_idx, rx_idx;
    logic tx_ninth, tx_line, tx_stop2;
    logic rx_ready, parity_err, overrun, framing, brk, addr_rx;
    logic rx_ninth, rx_done, rx_pe, rx_fe, rx_brk, rx_addr;
    logic [7:0] rx_done_data;
    logic req, wr, rd, data_wr, data_rd, tx_en, rx_line, ninth_on;
    logic [31:0] next_rdata;

    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr = req && wb_we_i && wb_sel_i[0];
    assign rd = req && !wb_we_i;
    assign data_wr = wr && wb_adr_i == ADDR_DATA;
    assign data_rd = rd && wb_adr_i == ADDR_DATA;
    assign ninth_on = ctl0[C0_PARITY_EN] || ctl1[C1_MP_MODE];
    assign tx_en = ctl0[C0_TX_ON] && !(ctl0[C0_CTS_GATE] && cts_sync);
    assign rx_line = ctl0[C0_LOOPBACK] ? txd : rxd_sync;

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rxd_meta <= 1'b1;
            rxd_sync <= 1'b1;
            cts_meta <= 1'b1;
            cts_sync <= 1'b1;
        end
        else
        begin
            rxd_meta <= rxd;
            rxd_sync <= rxd_meta;
            cts_meta <= cts_n;
            cts_sync <= cts_meta;
        end
    end

    // bus slave: one wait state, unmapped reads return zero
    always_comb
    begin
        next_rdata = 32'h0000_0000;
        case (wb_adr_i)
            ADDR_DATA: next_rdata[7:0] = rx_data;
            ADDR_STAT0: next_rdata[7:0] = {rx_ready, parity_err, overrun, framing, brk,
                                           tx_empty, !tx_busy, cts_sync};
            ADDR_CTL0: next_rdata[7:0] = ctl0;
            ADDR_CTL1: next_rdata[7:0] = ctl1;
            ADDR_STAT1: next_rdata[S1_ADDR_RX] = addr_rx;
            ADDR_BAUD_HI: next_rdata[7:0] = baud_hi;
            ADDR_BAUD_LO: next_rdata[7:0] = baud_lo;
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end
        else
        begin
            wb_ack_o <= req;
            if (rd)
                wb_dat_o <= next_rdata;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ctl0 <= CTL0_RESET;
            ctl1 <= CTL1_RESET;
            baud_hi <= BAUD_HI_RESET;
            baud_lo <= BAUD_LO_RESET;
        end
        else if (wr)
        begin
            case (wb_adr_i)
                ADDR_CTL0: ctl0 <= wb_dat_i[7:0];
                ADDR_CTL1: ctl1 <= wb_dat_i[7:0];
                ADDR_BAUD_HI: baud_hi <= wb_dat_i[7:0];
                ADDR_BAUD_LO: baud_lo <= wb_dat_i[7:0];
                default: ;
            endcase
        end
    end

    // divider: one tick per reload, sixteen ticks per bit; zero counts as one
    assign reload = baud_cnt <= 16'h0001;
    assign tick = reload;
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            baud_cnt <= 16'h0001;
        else if (reload)
            baud_cnt <= {baud_hi, baud_lo};
        else
            baud_cnt <= baud_cnt - 16'h0001;
    end

    // transmit holding register
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            tx_empty <= 1'b1;
            tx_hold <= 8'h00;
        end
        else if (data_wr)
        begin
            tx_empty <= 1'b0;
            tx_hold <= wb_dat_i[7:0];
        end
        else if (!tx_busy && !tx_empty && tx_en)
            tx_empty <= 1'b1;
    end

    // transmit shifter
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            tx_state <= UIMB_IDLE;
            tx_busy <= 1'b0;
            tx_shift <= 8'h00;
            tx_ninth <= 1'b0;
            tx_line <= 1'b1;
            tx_tick <= 4'h0;
            tx_idx <= 3'h0;
            tx_stop2 <= 1'b0;
        end
        else
        begin
            case (tx_state)
                UIMB_IDLE:
                begin
                    tx_line <= 1'b1;
                    if (!tx_empty && tx_en && !data_wr)
                    begin
                        tx_busy <= 1'b1;
                        tx_shift <= tx_hold;
                        tx_ninth <= ctl1[C1_MP_MODE] ? ctl1[C1_TX_ADDR_BIT]
                                    : (^tx_hold) ^ ctl0[C0_PARITY_ODD];
                        tx_tick <= 4'h0;
                        tx_idx <= 3'h0;
                        tx_state <= UIMB_START;
                    end
                end
                UIMB_START:
                begin
                    tx_line <= 1'b0;
                    if (tick)
                    begin
                        tx_tick <= tx_tick + 4'h1;
                        if (tx_tick == TICK_LAST)
                            tx_state <= UIMB_DATA;
                    end
                end
                UIMB_DATA:
                begin
                    tx_line <= tx_shift[tx_idx];
                    if (tick)
                    begin
                        tx_tick <= tx_tick + 4'h1;
                        if (tx_tick == TICK_LAST)
                        begin
                            tx_idx <= tx_idx + 3'h1;
                            if (tx_idx == DATA_LAST)
                            begin
                                tx_stop2 <= ctl0[C0_TWO_STOP];
                                tx_state <= ninth_on ? UIMB_NINTH : UIMB_STOP;
                            end
                        end
                    end
                end
                UIMB_NINTH:
                begin
                    tx_line <= tx_ninth;
                    if (tick)
                    begin
                        tx_tick <= tx_tick + 4'h1;
                        if (tx_tick == TICK_LAST)
                            tx_state <= UIMB_STOP;
                    end
                end
                UIMB_STOP:
                begin
                    tx_line <= 1'b1;
                    if (tick)
                    begin
                        tx_tick <= tx_tick + 4'h1;
                        if (tx_tick == TICK_LAST)
                        begin
                            tx_stop2 <= 1'b0;
                            if (!tx_stop2)
                            begin
                                tx_busy <= 1'b0;
                                tx_state <= UIMB_IDLE;
                            end
                        end
                    end
                end
                default: tx_state <= UIMB_IDLE;
            endcase
        end
    end

    // receive shifter: samples mid-bit, checks the first stop bit only
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rx_state <= UIMB_IDLE;
            rx_tick <= 4'h0;
            rx_idx <= 3'h0;
            rx_shift <= 8'h00;
            rx_ninth <= 1'b0;
            rx_done <= 1'b0;
            rx_done_data <= 8'h00;
            rx_pe <= 1'b0;
            rx_fe <= 1'b0;
            rx_brk <= 1'b0;
            rx_addr <= 1'b0;
        end
        else
        begin
            rx_done <= 1'b0;
            case (rx_state)
                UIMB_IDLE:
                begin
                    rx_tick <= 4'h0;
                    rx_idx <= 3'h0;
                    if (ctl0[C0_RX_ON] && !rx_line)
                        rx_state <= UIMB_START;
                end
                UIMB_START:
                    if (tick)
                    begin
                        rx_tick <= rx_tick + 4'h1;
                        if (rx_tick == TICK_MID)
                        begin
                            rx_tick <= 4'h0;
                            rx_state <= rx_line ? UIMB_IDLE : UIMB_DATA;
                        end
                    end
                UIMB_DATA:
                    if (tick)
                    begin
                        rx_tick <= rx_tick + 4'h1;
                        if (rx_tick == TICK_LAST)
                        begin
                            rx_shift <= {rx_line, rx_shift[7:1]};
                            rx_idx <= rx_idx + 3'h1;
                            if (rx_idx == DATA_LAST)
                                rx_state <= ninth_on ? UIMB_NINTH : UIMB_STOP;
                        end
                    end
                UIMB_NINTH:
                    if (tick)
                    begin
                        rx_tick <= rx_tick + 4'h1;
                        if (rx_tick == TICK_LAST)
                        begin
                            rx_ninth <= rx_line;
                            rx_state <= UIMB_STOP;
                        end
                    end
                UIMB_STOP:
                    if (tick)
                    begin
                        rx_tick <= rx_tick + 4'h1;
                        if (rx_tick == TICK_LAST)
                        begin
                            rx_done <= 1'b1;
                            rx_done_data <= rx_shift;
                            rx_fe <= !rx_line;
                            rx_brk <= !rx_line && rx_shift == 8'h00 && !(ninth_on && rx_ninth);
                            rx_pe <= ctl0[C0_PARITY_EN] && !ctl1[C1_MP_MODE]
                                     && ((^rx_shift) ^ ctl0[C0_PARITY_ODD] ^ rx_ninth);
                            rx_addr <= ctl1[C1_MP_MODE] && rx_ninth;
                            rx_ninth <= 1'b0;
                            rx_state <= UIMB_IDLE;
                        end
                    end
                default: rx_state <= UIMB_IDLE;
            endcase
        end
    end

    // receive flags: a completing byte wins over a same-cycle read
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rx_data <= 8'h00;
            rx_ready <= 1'b0;
            parity_err <= 1'b0;
            overrun <= 1'b0;
            framing <= 1'b0;
            brk <= 1'b0;
            addr_rx <= 1'b0;
        end
        else if (rx_done)
        begin
            rx_data <= rx_done_data;
            rx_ready <= 1'b1;
            overrun <= overrun || (rx_ready && !data_rd);
            parity_err <= rx_pe;
            framing <= rx_fe;
            brk <= rx_brk;
            addr_rx <= rx_addr;
        end
        else if (data_rd)
        begin
            rx_ready <= 1'b0;
            parity_err <= 1'b0;
            framing <= 1'b0;
            brk <= 1'b0;
            overrun <= 1'b0;
            addr_rx <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            txd <= 1'b1;
        else
            txd <= ctl0[C0_SEND_BREAK] ? 1'b0 : tx_line;
    end
    assign tx_irq = tx_empty;
    assign dma_req = rx_ready;
    // errors are never gated, so dma use still sees them
    assign rx_irq = (rx_ready && ctl1[C1_RX_BYTE_IRQ])
                    || parity_err || overrun || framing || brk
                    || (ctl1[C1_TIMER_IRQ] && !ctl0[C0_TX_ON] && !ctl0[C0_RX_ON] && reload);
endmodule : uimb_uart

// file: design/uimb_pkg.sv
package uimb_pkg;
    localparam logic [7:0] ADDR_DATA = 8'h00;
    localparam logic [7:0] ADDR_STAT0 = 8'h04;
    localparam logic [7:0] ADDR_CTL0 = 8'h08;
    localparam logic [7:0] ADDR_CTL1 = 8'h0C;
    localparam logic [7:0] ADDR_STAT1 = 8'h10;
    localparam logic [7:0] ADDR_BAUD_HI = 8'h14;
    localparam logic [7:0] ADDR_BAUD_LO = 8'h18;
    // status 0 fields
    localparam int S0_RX_READY = 7;
    localparam int S0_PARITY_ERR = 6;
    localparam int S0_OVERRUN = 5;
    localparam int S0_FRAMING = 4;
    localparam int S0_BREAK = 3;
    localparam int S0_TX_EMPTY = 2;
    localparam int S0_SHIFT_EMPTY = 1;
    localparam int S0_CTS = 0;
    // control 0 fields
    localparam int C0_TX_ON = 7;
    localparam int C0_RX_ON = 6;
    localparam int C0_CTS_GATE = 5;
    localparam int C0_PARITY_EN = 4;
    localparam int C0_PARITY_ODD = 3;
    localparam int C0_SEND_BREAK = 2;
    localparam int C0_TWO_STOP = 1;
    localparam int C0_LOOPBACK = 0;
    // control 1 fields
    localparam int C1_TIMER_IRQ = 7;
    localparam int C1_MP_MODE = 6;
    localparam int C1_TX_ADDR_BIT = 4;
    localparam int C1_RX_BYTE_IRQ = 1;
    // status 1 fields
    localparam int S1_ADDR_RX = 0;
    localparam logic [7:0] CTL0_RESET = 8'h00;
    localparam logic [7:0] CTL1_RESET = 8'h00;
    localparam logic [7:0] BAUD_HI_RESET = 8'h00;
    localparam logic [7:0] BAUD_LO_RESET = 8'h01;
    // ticks per bit and mid-bit sampling point
    localparam logic [3:0] TICK_LAST = 4'hF;
    localparam logic [3:0] TICK_MID = 4'h7;
    localparam logic [2:0] DATA_LAST = 3'h7;
    typedef enum logic [2:0] {
        UIMB_IDLE = 3'b000,
        UIMB_START = 3'b001,
        UIMB_DATA = 3'b011,
        UIMB_NINTH = 3'b010,
        UIMB_STOP = 3'b110
    } uimb_state_e;
endpackage : uimb_pkg

// file: testbench/uimb_uart_monitor.sv
`timescale 1ns/1ps
module uimb_uart_mon
    import uimb_pkg::*;
(
    input wire logic ref_clk, // clock
    input wire logic reset_n, // reset
    input wire logic wb_cyc_i, // cycle
    input wire logic wb_stb_i, // strobe
    input wire logic wb_we_i, // write
    input wire logic [7:0] wb_adr_i, // address
    input wire logic [3:0] wb_sel_i, // lanes
    input wire logic [31:0] wb_dat_o, // read data
    input wire logic wb_ack_o, // ack
    input wire logic txd, // serial out
    input wire logic tx_irq, // tx interrupt
    input wire logic dma_req // dma request
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);
    logic rd_ack;
    assign rd_ack = wb_ack_o && !wb_we_i;
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
    ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
    ack_delay_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
    read_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("upper read bits set");
    tx_clear_a: assert property (wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == ADDR_DATA
        |-> ##[0:1] !tx_irq) else $error("tx irq not cleared");
    dma_drop_a: assert property (rd_ack && wb_adr_i == ADDR_DATA |-> ##[0:1] !dma_req)
        else $error("dma request stuck");
    start_len_a: assert property ($fell(txd) |-> !txd [*8]) else $error("start bit short");
    ready_view_a: assert property (rd_ack && wb_adr_i == ADDR_STAT0
        |-> wb_dat_o[S0_RX_READY] == $past(dma_req)) else $error("ready flag wrong");
    empty_view_a: assert property (rd_ack && wb_adr_i == ADDR_STAT0
        |-> wb_dat_o[S0_TX_EMPTY] == $past(tx_irq)) else $error("tx empty flag wrong");
    reset_idle_a: assert property ($rose(reset_n) |-> txd && tx_irq && !dma_req) else $error("bad reset state");
endmodule : uimb_uart_mon
bind uimb_uart uimb_uart_mon mon (.ref_clk, .reset_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_o, .wb_ack_o, .txd, .tx_irq, .dma_req);

// file: testbench/uimb_node.sv
`timescale 1ns/1ps
module uimb_node #(parameter int BIT = 16)
(
    input wire logic ref_clk, // system clock
    input wire logic txd, // line from block
    output logic rxd // line to block
);
    logic [9:0] got = 10'h0;
    int frames = 0;
    initial rxd = 1'b1;
    // sample mid-bit after each start edge: data, ninth, stop
    always
    begin
        @(negedge txd);
        repeat (BIT / 2) @(posedge ref_clk);
        for (int i = 0; i < 10; i++)
        begin
            repeat (BIT) @(posedge ref_clk);
            got[i] = txd;
        end
        frames++;
    end
    task automatic send(input logic [7:0] d, input logic nb, input logic has9, input logic stp);
        logic [11:0] f;
        int n;
        n = has9 ? 11 : 10;
        @(posedge ref_clk);
        f = has9 ? {1'b1, stp, nb, d, 1'b0} : {2'b11, stp, d, 1'b0};
        for (int i = 0; i <= n; i++)
        begin
            rxd <= f[i];
            repeat (BIT) @(posedge ref_clk);
        end
    endtask : send
endmodule : uimb_node

// file: testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import uimb_pkg::*;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0;
    logic [3:0] wb_sel_i = 4'hF;
    logic cts_n = 1'b0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o, rxd, txd, tx_irq, rx_irq, dma_req;
    int bad_count = 0;
    int checks_done = 0;
    int ticks = 0;
    logic [7:0] q;
    always #4 ref_clk = ~ref_clk;
    uimb_uart dut (.ref_clk, .reset_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_sel_i,
        .wb_dat_o, .wb_ack_o, .rxd, .txd, .cts_n, .tx_irq, .rx_irq, .dma_req);
    uimb_node node (.ref_clk, .txd, .rxd);
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : finish_test
    always @(posedge ref_clk)
    begin
        ticks++;
        if (ticks == 30000)
        begin
            bad_count++;
            $display("MISMATCH at %0t: run timed out", $time);
            finish_test();
        end
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= {24'h0, d};
        do @(posedge ref_clk); while (wb_ack_o !== 1'b1);
        q = wb_dat_o[7:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask : bus
    // bounded wait for a new captured frame or for the dma request
    task automatic wait_for(input int f0, input logic on_dma);
        int n;
        n = 0;
        while ((on_dma ? dma_req !== 1'b1 : node.frames == f0) && n < 400)
        begin
            @(posedge ref_clk);
            n++;
        end
        if (n >= 400)
        begin
            bad_count++;
            $display("MISMATCH at %0t: wait timed out", $time);
        end
        #1;
    endtask : wait_for
    task automatic t_reset();
        logic [7:0] a[6] = '{ADDR_CTL0, ADDR_CTL1, ADDR_BAUD_HI, ADDR_BAUD_LO, 8'h1C, ADDR_STAT0};
        logic [7:0] e[6] = '{CTL0_RESET, CTL1_RESET, BAUD_HI_RESET, BAUD_LO_RESET, 8'h00, 8'h06};
        bus(1'b1, 8'h1C, 8'hFF);
        for (int i = 0; i < 6; i++)
        begin
            bus(1'b0, a[i], 8'h00);
            chk(q & (i == 5 ? 8'hFE : 8'hFF), e[i]);
        end
    endtask : t_reset
    task automatic t_timer();
        int n;
        bus(1'b1, ADDR_BAUD_LO, 8'h08);
        bus(1'b1, ADDR_CTL1, 8'h80);
        for (int k = 0; k < 2; k++)
        begin
            n = 0;
            repeat (80)
            begin
                @(posedge ref_clk);
                n += (rx_irq === 1'b1);
            end
            chk({7'h0, k == 0 ? n >= 9 && n <= 11 : n == 0}, 8'h01);
            bus(1'b1, ADDR_CTL0, 8'h80);
        end
        bus(1'b1, ADDR_CTL1, 8'h00);
        bus(1'b1, ADDR_BAUD_LO, 8'h01);
    endtask : t_timer
    task automatic t_tx();
        logic [7:0] c0[5] = '{8'h80, 8'h92, 8'h9A, 8'h90, 8'h90};
        logic [7:0] c1[5] = '{8'h00, 8'h00, 8'h00, 8'h50, 8'h40};
        logic [7:0] d[5] = '{8'hA5, 8'h5B, 8'h5B, 8'h3C, 8'hC3};
        logic e9;
        int f0;
        for (int i = 0; i < 5; i++)
        begin
            e9 = c1[i][C1_MP_MODE] ? c1[i][C1_TX_ADDR_BIT] : !c0[i][C0_PARITY_EN] | (^d[i] ^ c0[i][C0_PARITY_ODD]);
            bus(1'b1, ADDR_CTL1, c1[i]);
            bus(1'b1, ADDR_CTL0, c0[i]);
            f0 = node.frames;
            bus(1'b1, ADDR_DATA, d[i]);
            wait_for(f0, 1'b0);
            chk(node.got[7:0], d[i]);
            chk({7'h0, node.got[8]}, {7'h0, e9});
            chk({7'h0, node.got[9] & tx_irq}, 8'h01);
        end
    endtask : t_tx
    task automatic t_cts();
        int f0;
        bus(1'b1, ADDR_CTL1, 8'h00);
        bus(1'b1, ADDR_CTL0, 8'hA0);
        cts_n <= 1'b1;
        f0 = node.frames;
        bus(1'b1, ADDR_DATA, 8'h55);
        repeat (60) @(posedge ref_clk);
        chk({6'h0, node.frames == f0, tx_irq}, 8'h02);
        cts_n <= 1'b0;
        wait_for(f0, 1'b0);
        chk(node.got[7:0], 8'h55);
        bus(1'b1, ADDR_CTL0, 8'h80);
        cts_n <= 1'b1;
        f0 = node.frames;
        bus(1'b1, ADDR_DATA, 8'h66);
        wait_for(f0, 1'b0);
        chk(node.got[7:0], 8'h66);
        @(posedge ref_clk) cts_n <= 1'b0;
    endtask : t_cts
    task automatic t_rx();
        bus(1'b1, ADDR_CTL1, 8'h02);
        bus(1'b1, ADDR_CTL0, 8'h40);
        node.send(8'h3C, 1'b0, 1'b0, 1'b1);
        wait_for(0, 1'b1);
        chk({7'h0, rx_irq}, 8'h01);
        bus(1'b0, ADDR_STAT0, 8'h00);
        chk(q & 8'hF8, 8'h80);
        bus(1'b0, ADDR_DATA, 8'h00);
        chk(q, 8'h3C);
        @(posedge ref_clk);
        #1;
        chk({6'h0, dma_req, rx_irq}, 8'h00);
    endtask : t_rx
    task automatic t_rx_err();
        logic [7:0] d[4] = '{8'h11, 8'h00, 8'h01, 8'h01};
        logic [7:0] m[4] = '{8'h10, 8'h08, 8'h40, 8'h40};
        logic [7:0] e[4] = '{8'h10, 8'h08, 8'h40, 8'h00};
        bus(1'b1, ADDR_CTL1, 8'h00);
        node.send(8'h81, 1'b0, 1'b0, 1'b1);
        wait_for(0, 1'b1);
        chk({6'h0, dma_req, rx_irq}, 8'h02);
        node.send(8'h82, 1'b0, 1'b0, 1'b1);
        repeat (4) @(posedge ref_clk);
        #1;
        chk({7'h0, rx_irq}, 8'h01);
        bus(1'b0, ADDR_STAT0, 8'h00);
        chk(q & 8'hE0, 8'hA0);
        bus(1'b0, ADDR_DATA, 8'h00);
        chk(q, 8'h82);
        // framing, break, even parity error, odd parity good
        for (int i = 0; i < 4; i++)
        begin
            bus(1'b1, ADDR_CTL0, i < 2 ? 8'h40 : (i == 2 ? 8'h50 : 8'h58));
            node.send(d[i], 1'b0, i >= 2, i >= 2);
            repeat (4) @(posedge ref_clk);
            #1;
            chk({7'h0, rx_irq}, {7'h0, i < 3});
            bus(1'b0, ADDR_STAT0, 8'h00);
            chk(q & m[i], e[i]);
            bus(1'b0, ADDR_DATA, 8'h00);
        end
        bus(1'b0, ADDR_STAT0, 8'h00);
        chk(q & 8'hF8, 8'h00);
        bus(1'b1, ADDR_CTL1, 8'h42);
        bus(1'b1, ADDR_CTL0, 8'h50);
        node.send(8'h77, 1'b1, 1'b1, 1'b1);
        wait_for(0, 1'b1);
        bus(1'b0, ADDR_STAT1, 8'h00);
        chk(q, 8'h01);
        bus(1'b0, ADDR_STAT0, 8'h00);
        chk(q & 8'h40, 8'h00);
        bus(1'b0, ADDR_DATA, 8'h00);
        chk(q, 8'h77);
        bus(1'b1, ADDR_CTL0, 8'h80);
        node.send(8'h12, 1'b0, 1'b0, 1'b1);
        repeat (8) @(posedge ref_clk);
        chk({7'h0, dma_req}, 8'h00);
    endtask : t_rx_err
    // loopback frame, then a forced low line and its release
    task automatic t_loop();
        bus(1'b1, ADDR_CTL0, 8'hC1);
        bus(1'b1, ADDR_DATA, 8'h5A);
        bus(1'b0, ADDR_STAT0, 8'h00);
        chk(q & 8'h02, 8'h00);
        wait_for(0, 1'b1);
        bus(1'b0, ADDR_DATA, 8'h00);
        chk(q, 8'h5A);
        bus(1'b1, ADDR_CTL0, 8'h84);
        repeat (16) @(posedge ref_clk);
        chk({7'h0, txd}, 8'h00);
        bus(1'b1, ADDR_CTL0, 8'h80);
        repeat (2) @(posedge ref_clk);
        chk({7'h0, txd}, 8'h01);
    endtask : t_loop
    initial
    begin
        repeat (8) @(posedge ref_clk);
        reset_n <= 1'b1;
        t_reset();
        t_timer();
        t_tx();
        t_cts();
        t_rx();
        t_rx_err();
        t_loop();
        finish_test();
    end
endmodule : tb_top
